// ---- srwp_regs.svh ----
// Summary of operation
// - Host protects the region by enter sequence then sector-protect algorithm, reset high.
// - Once enter or protect has ended, host issues the exit sequence or a reset pulse before touching the rest of the array.
// - A write needs chip-select and write-strobe low with output-enable high.
// - Program is accepted only after the unlock write cycles.
// - Below the lockout supply the host starts no new operation; a sequence already running still completes.
`ifndef SRWP_REGS_SVH
`define SRWP_REGS_SVH

`define SRWP_OFS_CTRL      8'h00
`define SRWP_OFS_ADDR      8'h04
`define SRWP_OFS_WDATA     8'h08
`define SRWP_OFS_STATUS    8'h0C
`define SRWP_OFS_RDATA     8'h10

`define SRWP_CTRL_OP_LSB   0
`define SRWP_CTRL_WP_BIT   8
`define SRWP_CTRL_RST_BIT  9
`define SRWP_ST_BUSY       0
`define SRWP_ST_SECURE     1
`define SRWP_ST_REFUSED    2
`define SRWP_ST_INDICATOR  3
`define SRWP_ST_PWR_GOOD   4

`define SRWP_UNLOCK_A1     24'h00_0555
`define SRWP_UNLOCK_A2     24'h00_02AA
`define SRWP_UNLOCK_D1     16'h00AA
`define SRWP_UNLOCK_D2     16'h0055
`define SRWP_CMD_ENTER     16'h0088
`define SRWP_CMD_EXIT      16'h0090
`define SRWP_CMD_EXIT2     16'h0000
`define SRWP_CMD_PROGRAM   16'h00A0
`define SRWP_CMD_PROTECT   16'h0060
`define SRWP_INDICATOR_BIT 7

`define SRWP_CLK_NS        10
`define SRWP_SETUP_NS      10
`define SRWP_WE_LOW_NS     35
`define SRWP_RD_ACC_NS     110
`define SRWP_RECOV_NS      20
`define SRWP_RST_LOW_NS    500
`define SRWP_CEIL(ns)      (((ns) + `SRWP_CLK_NS - 1) / `SRWP_CLK_NS)

`endif

// ---- srwp_pkg.sv ----
package srwp_pkg;

	typedef enum logic [2:0] {
		OP_NONE    = 3'b000,
		OP_READ    = 3'b001,
		OP_PROGRAM = 3'b010,
		OP_ENTER   = 3'b011,
		OP_EXIT    = 3'b100,
		OP_PROTECT = 3'b101
	} srwp_op_e;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_SETUP  = 2'b01,
		ST_STROBE = 2'b10,
		ST_RECOV  = 2'b11
	} srwp_state_e;

	typedef struct packed {
		logic        rd;
		logic        last;
		logic [23:0] addr;
		logic [15:0] data;
	} srwp_step_s;

endpackage : srwp_pkg

// ---- srwp_host.sv ----
`timescale 1ns/1ps
`include "srwp_regs.svh"

module srwp_host #(
	parameter int SECTOR_WORDS = 65536
) (
	input  wire logic        CLK,
	input  wire logic        SYS_RST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        POWER_GOOD,
	output logic      [23:0] FL_ADDR,
	input  wire logic [15:0] FL_DQ_IN,
	output logic      [15:0] FL_DQ_OUT,
	output logic             FL_DQ_OE,
	output logic             FL_CE_N,
	output logic             FL_WE_N,
	output logic             FL_OE_N,
	output logic             FL_RESET_N,
	output logic             FL_PROTECT_OR_ACCELERATE_N
);

	localparam logic [7:0] SETUP_CYC = 8'(`SRWP_CEIL(`SRWP_SETUP_NS));
	localparam logic [7:0] WE_CYC    = 8'(`SRWP_CEIL(`SRWP_WE_LOW_NS));
	localparam logic [7:0] RD_CYC    = 8'(`SRWP_CEIL(`SRWP_RD_ACC_NS));
	localparam logic [7:0] RECOV_CYC = 8'(`SRWP_CEIL(`SRWP_RECOV_NS));
	localparam logic [7:0] RST_CYC   = 8'(`SRWP_CEIL(`SRWP_RST_LOW_NS));

	// =====================================================================
	// Bus-cycle table: every program and mode sequence opens with the unlocks.
	// =====================================================================
	function automatic srwp_pkg::srwp_step_s step_f(srwp_pkg::srwp_op_e op,
			logic [2:0] idx, logic [23:0] a, logic [15:0] d);
		srwp_pkg::srwp_step_s s;
		s = '{rd: 1'b0, last: 1'b0, addr: `SRWP_UNLOCK_A1, data: `SRWP_UNLOCK_D1};
		if (idx == 3'h1) begin
			s.addr = `SRWP_UNLOCK_A2;
			s.data = `SRWP_UNLOCK_D2;
		end
		case (op)
			srwp_pkg::OP_READ: begin
				s = '{rd: 1'b1, last: 1'b1, addr: a, data: 16'h0000};
			end
			srwp_pkg::OP_PROGRAM: begin
				if (idx == 3'h2) s.data = `SRWP_CMD_PROGRAM;
				if (idx == 3'h3) s = '{rd: 1'b0, last: 1'b1, addr: a, data: d};
			end
			srwp_pkg::OP_ENTER: begin
				if (idx == 3'h2) s = '{rd: 1'b0, last: 1'b1, addr: `SRWP_UNLOCK_A1,
					data: `SRWP_CMD_ENTER};
			end
			srwp_pkg::OP_EXIT: begin
				if (idx == 3'h2) s.data = `SRWP_CMD_EXIT;
				if (idx == 3'h3) s = '{rd: 1'b0, last: 1'b1, addr: 24'h00_0000,
					data: `SRWP_CMD_EXIT2};
			end
			srwp_pkg::OP_PROTECT: begin
				if (idx == 3'h2) s.data = `SRWP_CMD_ENTER;
				if (idx == 3'h3 || idx == 3'h4) s = '{rd: 1'b0, last: 1'b0, addr: a,
					data: `SRWP_CMD_PROTECT};
				if (idx == 3'h5) s = '{rd: 1'b1, last: 1'b1, addr: a, data: 16'h0000};
			end
			default: begin
				s.last = 1'b1;
			end
		endcase
		return s;
	endfunction : step_f

	function automatic logic in_first_sector(logic [23:0] a);
		return a < 24'(SECTOR_WORDS);
	endfunction : in_first_sector

	// =====================================================================
	// Register file.
	// =====================================================================
	srwp_pkg::srwp_state_e state_reg, state_next;
	srwp_pkg::srwp_op_e    op_reg, nxt_op;
	srwp_pkg::srwp_step_s  step, nstep;
	logic [23:0] addr_reg;
	logic [15:0] wdata_reg, rdata_reg;
	logic [2:0]  idx_reg;
	logic [7:0]  cnt_reg, rst_cnt_reg;
	logic        secure_reg, refused_reg, wp_low_reg;

	wire         acc_phase = PSEL & PENABLE & ~PREADY;
	wire         wr_acc    = acc_phase & PWRITE;
	wire         busy      = (state_reg != srwp_pkg::ST_IDLE) || (rst_cnt_reg != 8'h00);
	wire [2:0]   req_op    = PWDATA[`SRWP_CTRL_OP_LSB +: 3];
	wire         ctrl_wr   = wr_acc && PADDR == `SRWP_OFS_CTRL;
	wire         is_array  = req_op == srwp_pkg::OP_READ || req_op == srwp_pkg::OP_PROGRAM ||
		req_op == srwp_pkg::OP_PROTECT;
	// Once an enter or protect sequence has ended only first-sector addresses are touched,
	// so the rest of the array waits for an exit sequence or a reset pulse.
	wire         bad_area  = secure_reg && is_array && !in_first_sector(addr_reg);
	wire         op_req    = ctrl_wr && req_op != srwp_pkg::OP_NONE;
	// A reset pulse and an operation in one write would pull reset under a running cycle.
	wire         start     = op_req && !busy && POWER_GOOD && !bad_area &&
		!PWDATA[`SRWP_CTRL_RST_BIT];
	wire         rst_req   = ctrl_wr && PWDATA[`SRWP_CTRL_RST_BIT] && !busy;
	wire         mapped    = PADDR == `SRWP_OFS_CTRL || PADDR == `SRWP_OFS_ADDR ||
		PADDR == `SRWP_OFS_WDATA || PADDR == `SRWP_OFS_STATUS || PADDR == `SRWP_OFS_RDATA;
	wire [31:0]  status    = {27'h000_0000, POWER_GOOD,
		rdata_reg[`SRWP_INDICATOR_BIT], refused_reg, secure_reg, busy};
	wire [31:0]  rd_mux    =
		PADDR == `SRWP_OFS_CTRL   ? {22'h00_0000, 1'b0, wp_low_reg, 5'h00, op_reg} :
		PADDR == `SRWP_OFS_ADDR   ? {8'h00, addr_reg} :
		PADDR == `SRWP_OFS_WDATA  ? {16'h0000, wdata_reg} :
		PADDR == `SRWP_OFS_STATUS ? status :
		PADDR == `SRWP_OFS_RDATA  ? {16'h0000, rdata_reg} : 32'h0000_0000;

	assign step = step_f(op_reg, idx_reg, addr_reg, wdata_reg);
	wire         from_idle  = state_reg == srwp_pkg::ST_IDLE;
	assign nxt_op = from_idle ? srwp_pkg::srwp_op_e'(req_op) : op_reg;
	assign nstep = step_f(nxt_op, from_idle ? 3'h0 : idx_reg + 3'h1, addr_reg, wdata_reg);
	wire [7:0]   strobe_len = step.rd ? RD_CYC : WE_CYC;
	wire         cnt_done   = cnt_reg == 8'h01;
	wire         seq_end    = state_reg == srwp_pkg::ST_RECOV && cnt_done && step.last;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			srwp_pkg::ST_IDLE:   if (start) state_next = srwp_pkg::ST_SETUP;
			srwp_pkg::ST_SETUP:  if (cnt_done) state_next = srwp_pkg::ST_STROBE;
			srwp_pkg::ST_STROBE: if (cnt_done) state_next = srwp_pkg::ST_RECOV;
			srwp_pkg::ST_RECOV: begin
				if (cnt_done) state_next = step.last ? srwp_pkg::ST_IDLE : srwp_pkg::ST_SETUP;
			end
			default: state_next = srwp_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			PREADY      <= 1'b0;
			PSLVERR     <= 1'b0;
			PRDATA      <= 32'h0000_0000;
			addr_reg    <= 24'h00_0000;
			wdata_reg   <= 16'h0000;
			op_reg      <= srwp_pkg::OP_NONE;
			wp_low_reg  <= 1'b0;
			refused_reg <= 1'b0;
		end else begin
			PREADY  <= acc_phase;
			PSLVERR <= acc_phase && !mapped;
			PRDATA  <= (acc_phase && !PWRITE) ? rd_mux : 32'h0000_0000;
			if (wr_acc && PADDR == `SRWP_OFS_ADDR) addr_reg <= PWDATA[23:0];
			if (wr_acc && PADDR == `SRWP_OFS_WDATA) wdata_reg <= PWDATA[15:0];
			if (ctrl_wr) wp_low_reg <= PWDATA[`SRWP_CTRL_WP_BIT];
			if (start) op_reg <= srwp_pkg::srwp_op_e'(req_op);
			// A refusal in the same cycle as the clear stays visible.
			if (op_req && !start) refused_reg <= 1'b1;
			else if (wr_acc && PADDR == `SRWP_OFS_STATUS && PWDATA[`SRWP_ST_REFUSED])
				refused_reg <= 1'b0;
		end
	end

	// =====================================================================
	// Flash pin sequencer.
	// =====================================================================
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			state_reg   <= srwp_pkg::ST_IDLE;
			idx_reg     <= 3'h0;
			cnt_reg     <= 8'h00;
			rst_cnt_reg <= 8'h00;
			rdata_reg   <= 16'h0000;
			secure_reg  <= 1'b0;
			FL_ADDR     <= 24'h00_0000;
			FL_DQ_OUT   <= 16'h0000;
			FL_DQ_OE    <= 1'b0;
			FL_CE_N     <= 1'b1;
			FL_WE_N     <= 1'b1;
			FL_OE_N     <= 1'b1;
			FL_RESET_N  <= 1'b1;
			FL_PROTECT_OR_ACCELERATE_N <= 1'b1;
		end else begin
			state_reg  <= state_next;
			FL_PROTECT_OR_ACCELERATE_N <= ~wp_low_reg;
			// The reset pin stays at the normal high level through protection.
			FL_RESET_N <= rst_cnt_reg == 8'h00 && !rst_req;
			if (rst_req) rst_cnt_reg <= RST_CYC;
			else if (rst_cnt_reg != 8'h00) rst_cnt_reg <= rst_cnt_reg - 8'h01;
			if (rst_req) secure_reg <= 1'b0;
			else if (seq_end && (op_reg == srwp_pkg::OP_ENTER || op_reg == srwp_pkg::OP_PROTECT))
				secure_reg <= 1'b1;
			else if (seq_end && op_reg == srwp_pkg::OP_EXIT) secure_reg <= 1'b0;
			case (state_next)
				srwp_pkg::ST_SETUP: begin
					if (state_reg != srwp_pkg::ST_SETUP) cnt_reg <= SETUP_CYC;
					else cnt_reg <= cnt_reg - 8'h01;
					FL_CE_N <= 1'b0;
				end
				srwp_pkg::ST_STROBE: begin
					// Write strobe only with chip-select low and output-enable high.
					if (state_reg != srwp_pkg::ST_STROBE) cnt_reg <= strobe_len;
					else cnt_reg <= cnt_reg - 8'h01;
					FL_WE_N <= step.rd;
					FL_OE_N <= !step.rd;
				end
				srwp_pkg::ST_RECOV: begin
					if (state_reg != srwp_pkg::ST_RECOV) begin
						cnt_reg <= RECOV_CYC;
						if (step.rd) rdata_reg <= FL_DQ_IN;
					end else begin
						cnt_reg <= cnt_reg - 8'h01;
					end
					FL_CE_N <= 1'b1;
					FL_WE_N <= 1'b1;
					FL_OE_N <= 1'b1;
				end
				default: begin
					cnt_reg <= 8'h00;
					FL_CE_N <= 1'b1;
					FL_WE_N <= 1'b1;
					FL_OE_N <= 1'b1;
				end
			endcase
			if (state_reg == srwp_pkg::ST_RECOV && cnt_done)
				idx_reg <= step.last ? 3'h0 : idx_reg + 3'h1;
			if (state_next == srwp_pkg::ST_SETUP && state_reg != srwp_pkg::ST_SETUP) begin
				FL_ADDR   <= nstep.addr;
				FL_DQ_OUT <= nstep.data;
				FL_DQ_OE  <= !nstep.rd;
			end else if (state_next == srwp_pkg::ST_IDLE) begin
				FL_DQ_OE <= 1'b0;
			end
		end
	end

	// =====================================================================
	// Checks.
	// =====================================================================
	logic [1:0] unlock_cnt;
	logic we_prev_reg;
	wire  we_rise = FL_WE_N && !we_prev_reg;

	// Reset to the idle level of the strobe so no false rise follows reset.
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) we_prev_reg <= 1'b1;
		else we_prev_reg <= FL_WE_N;
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) unlock_cnt <= 2'h0;
		else if (state_reg == srwp_pkg::ST_IDLE) unlock_cnt <= 2'h0;
		else if (we_rise && FL_DQ_OUT == `SRWP_UNLOCK_D1 && FL_ADDR == `SRWP_UNLOCK_A1)
			unlock_cnt <= 2'h1;
		else if (we_rise && FL_DQ_OUT == `SRWP_UNLOCK_D2 && unlock_cnt == 2'h1)
			unlock_cnt <= 2'h2;
	end

	sequence s_we_fall;
		$fell(FL_WE_N);
	endsequence
	sequence s_we_pulse;
		!FL_WE_N [*4] ##1 FL_WE_N;
	endsequence

	a_write_strobe_legal: assert property (@(posedge CLK) disable iff (SYS_RST)
		!FL_WE_N |-> !FL_CE_N && FL_OE_N && FL_DQ_OE) else $error("write strobe illegal");
	a_we_pulse_width: assert property (@(posedge CLK) disable iff (SYS_RST)
		s_we_fall |-> s_we_pulse) else $error("write pulse width wrong");
	a_idle_pins_quiet: assert property (@(posedge CLK) disable iff (SYS_RST)
		$past(state_reg) == srwp_pkg::ST_IDLE && state_reg == srwp_pkg::ST_IDLE
		|-> FL_CE_N && FL_WE_N && FL_OE_N) else $error("pins not quiet in idle");
	a_program_unlocked: assert property (@(posedge CLK) disable iff (SYS_RST)
		s_we_fall ##0 (FL_DQ_OUT == `SRWP_CMD_PROGRAM && FL_ADDR == `SRWP_UNLOCK_A1)
		|-> unlock_cnt == 2'h2) else $error("program without unlock");
	a_reset_during_protect: assert property (@(posedge CLK) disable iff (SYS_RST)
		state_reg != srwp_pkg::ST_IDLE |-> FL_RESET_N) else $error("reset low during cycle");
	a_exit_before_array: assert property (@(posedge CLK) disable iff (SYS_RST)
		start && secure_reg && is_array |-> ##1 in_first_sector(addr_reg) ##1 !FL_CE_N)
		else $error("array access with overlay active");
	a_overlay_read_first: assert property (@(posedge CLK) disable iff (SYS_RST)
		secure_reg && !FL_OE_N |-> in_first_sector(FL_ADDR))
		else $error("overlay read outside first sector");

endmodule : srwp_host

// ---- srwp_flash_model.sv ----
`timescale 1ns/1ps
// ========
// Flash die model: secure region overlay and write protection.
module srwp_flash_model #(
	parameter int SECTOR_WORDS   = 256,
	parameter bit FACTORY_LOCKED = 1'b0
) (
	input  wire logic [23:0] addr,
	input  wire logic [15:0] dq_in,
	output logic      [15:0] dq_out,
	input  wire logic        ce_n,
	input  wire logic        we_n,
	input  wire logic        oe_n,
	input  wire logic        reset_n,
	input  wire logic        protect_n,
	input  wire logic        supply_ok
);
	logic [15:0] array_mem [512];
	logic [15:0] secure_mem [128];
	logic [15:0] last_rd = 16'h0000;
	logic [15:0] rd_val;
	logic        overlay = 1'b0;
	logic        locked = FACTORY_LOCKED;
	logic        prog_pend = 1'b0;
	logic        exit_pend = 1'b0;
	logic        pwr_inh = 1'b0;
	logic        cyc_ok = 1'b0;
	logic        wr_ok = 1'b0;
	int          unlock_cnt = 0;
	realtime     we_fall = 0.0;
	wire         in_first = addr < SECTOR_WORDS;
	initial begin
		foreach (array_mem[i]) array_mem[i] = 16'hFFFF;
		foreach (secure_mem[i]) secure_mem[i] = 16'hFFFF;
	end
	always @(negedge we_n) begin
		we_fall = $realtime;
		cyc_ok = !ce_n && oe_n;
	end
	always @(posedge supply_ok) pwr_inh = !we_n && !ce_n && oe_n;
	always @(negedge reset_n or negedge supply_ok) begin
		overlay = 1'b0;
		unlock_cnt = 0;
		prog_pend = 1'b0;
		exit_pend = 1'b0;
	end
	// No bypass or accelerated path exists, so none is offered under the overlay.
	// The cycle ends at whichever of chip-select and write strobe rises first.
	always @(posedge we_n or posedge ce_n) begin
		wr_ok = cyc_ok;
		cyc_ok = 1'b0;
		if (!wr_ok || !oe_n || !reset_n || !supply_ok || $realtime - we_fall < 5.0) begin
		end else if (pwr_inh) begin
			pwr_inh = 1'b0;
		end else if (prog_pend) begin
			prog_pend = 1'b0;
			if (overlay && in_first && !locked) secure_mem[addr[6:0]] &= dq_in;
			else if (!overlay && !(in_first && !protect_n)) array_mem[addr[8:0]] &= dq_in;
		end else if (exit_pend && dq_in == 16'h0000) begin
			overlay = 1'b0;
			exit_pend = 1'b0;
		end else if (overlay && dq_in == 16'h0060) begin
			locked = 1'b1;
		end else if (unlock_cnt == 0 && addr == 24'h00_0555 && dq_in == 16'h00AA) begin
			unlock_cnt = 1;
		end else if (unlock_cnt == 1 && addr == 24'h00_02AA && dq_in == 16'h0055) begin
			unlock_cnt = 2;
		end else if (unlock_cnt == 2 && addr == 24'h00_0555) begin
			unlock_cnt = 0;
			prog_pend = dq_in == 16'h00A0;
			overlay |= dq_in == 16'h0088;
			exit_pend = dq_in == 16'h0090;
		end else begin
			unlock_cnt = 0;
		end
	end
	assign rd_val = (overlay && in_first) ? secure_mem[addr[6:0]] : array_mem[addr[8:0]];
	always @(posedge oe_n) last_rd = rd_val;
	// A released bus shows the inverse of the last word so stale data never passes.
	assign dq_out = (!oe_n && !ce_n) ? rd_val : ~last_rd;
endmodule : srwp_flash_model

// ---- srwp_host_bench.sv ----
`timescale 1ns/1ps
module srwp_host_bench;
	localparam int SW = 256;
	logic        CLK = 1'b0, SYS_RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
	logic        POWER_GOOD = 1'b1, PREADY, PSLVERR, FL_DQ_OE, FL_CE_N, FL_WE_N, FL_OE_N;
	logic        FL_RESET_N, FL_PROTECT_OR_ACCELERATE_N, wp_low = 1'b0;
	logic [7:0]  PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0000_0000, PRDATA, st;
	logic [23:0] FL_ADDR;
	logic [15:0] FL_DQ_OUT, dev_dq, fl_dq;
	int          miscompares = 0;
	int          num_checks = 0;
	assign fl_dq = FL_DQ_OE ? FL_DQ_OUT : dev_dq;
	always #5 CLK = ~CLK;
	srwp_host #(.SECTOR_WORDS(SW)) i_srwp_host (.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
		.PREADY(PREADY), .PSLVERR(PSLVERR), .POWER_GOOD(POWER_GOOD), .FL_ADDR(FL_ADDR),
		.FL_DQ_IN(fl_dq), .FL_DQ_OUT(FL_DQ_OUT), .FL_DQ_OE(FL_DQ_OE), .FL_CE_N(FL_CE_N),
		.FL_WE_N(FL_WE_N), .FL_OE_N(FL_OE_N), .FL_RESET_N(FL_RESET_N),
		.FL_PROTECT_OR_ACCELERATE_N(FL_PROTECT_OR_ACCELERATE_N));
	srwp_flash_model #(.SECTOR_WORDS(SW)) i_srwp_flash_model (.addr(FL_ADDR), .dq_in(fl_dq),
		.dq_out(dev_dq), .ce_n(FL_CE_N), .we_n(FL_WE_N), .oe_n(FL_OE_N), .reset_n(FL_RESET_N),
		.protect_n(FL_PROTECT_OR_ACCELERATE_N), .supply_ok(POWER_GOOD));
	// ========
	// Bus tasks.
	task automatic end_of_test;
		if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic err);
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		@(posedge CLK);
		while (PREADY !== 1'b1) @(posedge CLK);
		r = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0000_0000, r, e);
	endtask : rd_reg
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask : wr_reg
	task automatic op(input srwp_pkg::srwp_op_e o, input logic [23:0] a, input logic [15:0] d,
		input logic pulse);
		logic [31:0] s;
		wr_reg(8'h04, {8'h00, a});
		wr_reg(8'h08, {16'h0000, d});
		wr_reg(8'h00, {22'h00_0000, pulse, wp_low, 5'h00, o});
		s = 32'h0000_0001;
		for (int i = 0; i < 300 && s[0] !== 1'b0; i++) rd_reg(8'h0C, s);
		if (s[0] !== 1'b0) begin
			miscompares++;
			$display("MISMATCH %0t busy never cleared", $time);
		end
	endtask : op
	task automatic word(input logic [23:0] a, input logic [15:0] exp);
		logic [31:0] r;
		op(srwp_pkg::OP_READ, a, 16'h0000, 1'b0);
		rd_reg(8'h10, r);
		chk(r, {16'h0000, exp});
	endtask : word
	initial begin
		#200_000;
		miscompares++;
		$display("MISMATCH %0t watchdog expired", $time);
		end_of_test();
	end
	// ========
	// Tests.
	initial begin
		logic e;
		repeat (20) @(posedge CLK);
		SYS_RST <= 1'b0;
		rd_reg(8'h0C, st);
		chk(st, 32'h0000_0010);
		apb(1'b0, 8'h20, 32'h0000_0000, st, e);
		chk({31'h0, e}, 32'h0000_0001);
		op(srwp_pkg::OP_PROGRAM, 24'h00_0005, 16'h1234, 1'b0);
		word(24'h00_0005, 16'h1234);
		op(srwp_pkg::OP_ENTER, 24'h00_0000, 16'h0000, 1'b0);
		word(24'h00_0005, 16'hFFFF);
		rd_reg(8'h0C, st);
		chk(st, 32'h0000_001A);
		op(srwp_pkg::OP_PROGRAM, 24'h00_0005, 16'h0042, 1'b0);
		word(24'h00_0005, 16'h0042);
		op(srwp_pkg::OP_READ, 24'(SW), 16'h0000, 1'b0);
		rd_reg(8'h0C, st);
		chk({31'h0, st[2]}, 32'h0000_0001);
		wr_reg(8'h0C, 32'h0000_0004);
		op(srwp_pkg::OP_PROTECT, 24'h00_0000, 16'h0000, 1'b0);
		op(srwp_pkg::OP_PROGRAM, 24'h00_0006, 16'h0011, 1'b0);
		word(24'h00_0006, 16'hFFFF);
		op(srwp_pkg::OP_EXIT, 24'h00_0000, 16'h0000, 1'b0);
		word(24'h00_0005, 16'h1234);
		op(srwp_pkg::OP_ENTER, 24'h00_0000, 16'h0000, 1'b0);
		op(srwp_pkg::OP_NONE, 24'h00_0000, 16'h0000, 1'b1);
		rd_reg(8'h0C, st);
		chk(st, 32'h0000_0010);
		word(24'h00_0005, 16'h1234);
		wp_low = 1'b1;
		op(srwp_pkg::OP_PROGRAM, 24'h00_0007, 16'h0077, 1'b0);
		chk({31'h0, FL_PROTECT_OR_ACCELERATE_N}, 32'h0000_0000);
		word(24'h00_0007, 16'hFFFF);
		wp_low = 1'b0;
		op(srwp_pkg::OP_PROGRAM, 24'h00_0007, 16'h0077, 1'b0);
		word(24'h00_0007, 16'h0077);
		POWER_GOOD <= 1'b0;
		op(srwp_pkg::OP_PROGRAM, 24'h00_0008, 16'h0000, 1'b0);
		rd_reg(8'h0C, st);
		chk(st, 32'h0000_0004);
		end_of_test();
	end
endmodule : srwp_host_bench
